// ---- scpp_clk_model.sv ----
// Behavioural slow oscillators and external single-ended clock.
`timescale 1ns/1ps
`default_nettype none
module scpp_clk_model #(
   parameter int EXT_HALF_NS = 23,
   parameter int INT_HALF_NS = 31,
   parameter int XTAL_HALF_NS = 37
) (
   input wire logic extRun,
   output logic extClkIn,
   output logic xtalClkIn,
   output logic intOscClkIn
);
   logic extQ = 1'b0;
   logic intQ = 1'b0;
   logic xtalQ = 1'b0;
   // Free-running sources unrelated to the system clock in phase.
   always #(EXT_HALF_NS) if (extRun) extQ = ~extQ;
   always #(INT_HALF_NS) intQ = ~intQ;
   always #(XTAL_HALF_NS) xtalQ = ~xtalQ;
   // A stopped external clock simply holds its last level.
   assign extClkIn = extQ;
   assign intOscClkIn = intQ;
   assign xtalClkIn = xtalQ;
endmodule : scpp_clk_model
`default_nettype wire

// ---- scpp_edge_qual.sv ----
// Activity monitor for the single-ended external slow clock.
`timescale 1ns/1ps
`default_nettype none
module scpp_edge_qual
   import scpp_pkg::*;
#(
   parameter logic [15:0] LOSS_CYC = 16'(EXT_LOSS_CYC)
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic extLevel,
   output logic extAlive
);
   logic prev_q, prev_d;
   logic [GAP_W-1:0] gap_q, gap_d;
   logic [2:0] good_q, good_d;
   logic alive_q, alive_d;
   logic rise;

   // A gap longer than the loss time declares the clock stopped; the
   // clock is trusted again only after a run of closely spaced edges.
   always_comb begin
      prev_d = extLevel;
      rise = extLevel && !prev_q;
      gap_d = gap_q;
      good_d = good_q;
      alive_d = alive_q;
      if (rise) begin
         gap_d = '0;
         if (good_q != GOOD_EDGES) begin
            good_d = good_q + 3'h1; // R11
         end
         if (good_q == GOOD_EDGES - 3'h1) begin
            alive_d = 1'b1; // R11
         end
      end else if (gap_q > LOSS_CYC) begin
         good_d = '0;
         alive_d = 1'b0; // R6
      end else begin
         gap_d = gap_q + 16'h0001;
      end
   end

   // State registers.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prev_q <= 1'b0;
         gap_q <= '0;
         good_q <= '0;
         alive_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         gap_q <= gap_d;
         good_q <= good_d;
         alive_q <= alive_d;
      end
   end

   assign extAlive = alive_q;
endmodule : scpp_edge_qual
`default_nettype wire

// ---- scpp_pkg.sv ----
// Constants, types and register map of the slow clock and pin power block.
//
// Overview of operation
// [R1] Firmware recovery writes clock configuration 04h.
// [R2] Enables pick disabled, crystal or external clock.
// [R3] Internal oscillator alone keeps running rail off.
// [R4] Emulation set gates internal clock rail off.
// [R5] All enables set: external primary, switched source.
// [R6] Switched source falls back on loss or rail.
// [R7] Switched source, rail off: emulation gates internal.
// [R8] Power bit zero: follow GPIO, tristate rail off.
// [R9] Bit one set: battery output from own bit.
// [R10] Bit zero set: control output from battery logic.
// [R11] Return to external after several good edges.
// [R12] Automatic failover only while main rail powered.
// [R13] Reserved power bits read zero, ignore writes.
package scpp_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses.
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CLK_CFG = 8'h08;
   localparam logic [7:0] ADDR_PIN_PWR = 8'h18;
   localparam logic [7:0] ADDR_BAT_OUT = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;

   // ----------------------------------------------------------------
   // Clock configuration fields.
   // ----------------------------------------------------------------
   localparam int CFG_W = 6;
   localparam int CFG_XTAL_BYPASS = 0;
   localparam int CFG_EXT_EN = 1;
   localparam int CFG_INT_EN = 2;
   localparam int CFG_RAIL_EMUL = 3;
   localparam int CFG_FAIL_DIS = 4;
   localparam int CFG_REF_SEL = 5;
   localparam logic [5:0] CFG_RESET = 6'h00;
   localparam logic [5:0] CFG_BOOT_SAFE = 6'h04;

   // ----------------------------------------------------------------
   // Pin power source and battery output fields.
   // ----------------------------------------------------------------
   localparam int PWR_W = 2;
   localparam int PWR_CTRL_OUT = 0;
   localparam int PWR_GEN_OUT = 1;
   localparam logic [1:0] PWR_RESET = 2'h3;
   localparam logic BAT_OUT_RESET = 1'b0;

   // ----------------------------------------------------------------
   // Status fields.
   // ----------------------------------------------------------------
   localparam int ST_SRC_LO = 0;
   localparam int ST_EXT_ALIVE = 2;
   localparam int ST_RAIL = 3;
   localparam int ST_INT_RUN = 4;

   // ----------------------------------------------------------------
   // Bus answers and timing.
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int EXT_LOSS_NS = 100000;
   localparam int EXT_LOSS_CYC = (EXT_LOSS_NS * 1000) / CLK_PERIOD_PS;
   localparam int GAP_W = 16;
   localparam logic [2:0] GOOD_EDGES = 3'h4;

   // Selected slow clock source.
   typedef enum logic [1:0] {
      SRC_OFF,
      SRC_XTAL,
      SRC_EXT,
      SRC_INT
   } scpp_src_t;

endpackage : scpp_pkg

// ---- scpp_sync2.sv ----
// Two flip-flop synchroniser for asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module scpp_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] stable_q;
   logic [W-1:0] stable_d;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_d = asyncIn;
      stable_d = meta_q;
   end

   // Both stages clear on reset.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         meta_q <= '0;
         stable_q <= '0;
      end else begin
         meta_q <= meta_d;
         stable_q <= stable_d;
      end
   end

   assign syncOut = stable_q;
endmodule : scpp_sync2
`default_nettype wire

// ---- scpp_top.sv ----
// Slow clock source selection and pin power source control with AXI4-Lite.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module scpp_top
   import scpp_pkg::*;
#(
   parameter logic [15:0] LOSS_CYC = 16'(EXT_LOSS_CYC)
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [scpp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [scpp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic xtalClkIn,
   input wire logic extClkIn,
   input wire logic intOscClkIn,
   input wire logic mainRailGood,
   input wire logic gpioGenOutLevel,
   input wire logic gpioCtrlOutLevel,
   input wire logic ctrlLogicLevel,
   output logic slowClk,
   output scpp_pkg::scpp_src_t slowClkSrc,
   output logic intOscEnable,
   output logic xtalOscEnable,
   output logic refSelectSwitched,
   output logic genOutPin,
   output logic genOutPinOe,
   output logic ctrlOutPin,
   output logic ctrlOutPinOe
);
   // ----------------------------------------------------------------
   // Input synchronisation.
   // ----------------------------------------------------------------
   logic [3:0] pinSync;
   logic xtalS, extS, intS, railS;
   logic extAlive;

   // Clock pins and the rail monitor come from outside this domain.
   scpp_sync2 #(
      .W(4)
   ) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .asyncIn({mainRailGood, intOscClkIn, extClkIn, xtalClkIn}),
      .syncOut(pinSync)
   );

   assign xtalS = pinSync[0];
   assign extS = pinSync[1];
   assign intS = pinSync[2];
   assign railS = pinSync[3];

   // Watch the single-ended clock for loss and for recovery.
   scpp_edge_qual #(
      .LOSS_CYC(LOSS_CYC)
   ) u_qual (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .extLevel(extS),
      .extAlive(extAlive)
   );

   // ----------------------------------------------------------------
   // Registers and AXI4-Lite slave.
   // ----------------------------------------------------------------
   logic [CFG_W-1:0] cfg_q, cfg_d;
   logic [PWR_W-1:0] pwr_q, pwr_d;
   logic batOut_q, batOut_d;
   logic awHeld_q, awHeld_d;
   logic wHeld_q, wHeld_d;
   logic [ADDR_W-1:0] awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic bValid_q, bValid_d;
   logic [1:0] bResp_q, bResp_d;
   logic rValid_q, rValid_d;
   logic [31:0] rData_q, rData_d;
   logic [1:0] rResp_q, rResp_d;
   logic [31:0] statusWord;

   // True for any address that holds a register.
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      isMapped = (a == ADDR_CLK_CFG) || (a == ADDR_PIN_PWR) ||
                 (a == ADDR_BAT_OUT) || (a == ADDR_STATUS);
   endfunction : isMapped

   // Address and data are each held until the other arrives.
   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready = !wHeld_q && !bValid_q;
   assign s_axi_arready = !rValid_q;

   // Write path: capture channels, commit once both are held.
   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      awAddr_d = awAddr_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bValid_d = bValid_q;
      bResp_d = bResp_q;
      cfg_d = cfg_q;
      pwr_d = pwr_q;
      batOut_d = batOut_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awHeld_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeld_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      if (awHeld_q && wHeld_q) begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bValid_d = 1'b1;
         bResp_d = isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
         if (wStrb_q[0]) begin
            case (awAddr_q)
               ADDR_CLK_CFG: begin
                  cfg_d = wData_q[CFG_W-1:0]; // R2
               end
               ADDR_PIN_PWR: begin
                  pwr_d = wData_q[PWR_W-1:0]; // R13
               end
               ADDR_BAT_OUT: begin
                  batOut_d = wData_q[0]; // R9
               end
               default: begin
                  cfg_d = cfg_q;
               end
            endcase
         end
      end else if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
   end

   // Status word gathers the live selection state.
   always_comb begin
      statusWord = '0;
      statusWord[ST_SRC_LO +: 2] = slowClkSrc;
      statusWord[ST_EXT_ALIVE] = extAlive;
      statusWord[ST_RAIL] = railS;
      statusWord[ST_INT_RUN] = intOscEnable;
   end

   // Read path: one cycle from address to data.
   always_comb begin
      rValid_d = rValid_q;
      rData_d = rData_q;
      rResp_d = rResp_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_d = 1'b1;
         rData_d = '0;
         rResp_d = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CLK_CFG: begin
               rData_d[CFG_W-1:0] = cfg_q;
            end
            ADDR_PIN_PWR: begin
               rData_d[PWR_W-1:0] = pwr_q; // R13
            end
            ADDR_BAT_OUT: begin
               rData_d[0] = batOut_q;
            end
            ADDR_STATUS: begin
               rData_d = statusWord;
            end
            default: begin
               rResp_d = RESP_SLVERR;
            end
         endcase
      end else if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
   end

   // Register and bus state.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_q <= CFG_RESET;
         pwr_q <= PWR_RESET; // R9 R10
         batOut_q <= BAT_OUT_RESET;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
         rValid_q <= 1'b0;
         rData_q <= '0;
         rResp_q <= RESP_OKAY;
      end else begin
         cfg_q <= cfg_d;
         pwr_q <= pwr_d;
         batOut_q <= batOut_d;
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         bValid_q <= bValid_d;
         bResp_q <= bResp_d;
         rValid_q <= rValid_d;
         rData_q <= rData_d;
         rResp_q <= rResp_d;
      end
   end

   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   // ----------------------------------------------------------------
   // Slow clock source selection.
   // ----------------------------------------------------------------
   scpp_src_t src_q, src_d;
   logic intRun_q, intRun_d;
   logic xtalEn_q, xtalEn_d;
   logic slowClk_q, slowClk_d;
   logic refSel_q, refSel_d;
   logic bypass, extEn, intEn, emul, failDis, switched, intGated;

   assign bypass = cfg_q[CFG_XTAL_BYPASS];
   assign extEn = cfg_q[CFG_EXT_EN];
   assign intEn = cfg_q[CFG_INT_EN];
   assign emul = cfg_q[CFG_RAIL_EMUL];
   assign failDis = cfg_q[CFG_FAIL_DIS];
   assign switched = bypass && extEn && intEn && !failDis; // R5
   // With emulation set the internal clock dies with the rail.
   assign intGated = emul && !railS; // R4 R7

   // Decode the enables into a source and oscillator enables.
   always_comb begin
      src_d = SRC_OFF;
      intRun_d = 1'b0;
      xtalEn_d = 1'b0;
      if (extEn && !bypass) begin
         src_d = SRC_XTAL; // R2
         xtalEn_d = 1'b1;
      end else if (switched) begin
         // Fall back on loss or rail off; switch only with rail on.
         if (railS && extAlive) begin
            src_d = SRC_EXT; // R5 R12
         end else begin
            src_d = intGated ? SRC_OFF : SRC_INT; // R6 R7
         end
         intRun_d = !intGated; // R7
      end else if (extEn) begin
         src_d = SRC_EXT; // R2
      end else if (intEn) begin
         src_d = intGated ? SRC_OFF : SRC_INT; // R3 R4
         intRun_d = !intGated; // R3
      end
      case (src_q)
         SRC_XTAL: slowClk_d = xtalS;
         SRC_EXT: slowClk_d = extS;
         SRC_INT: slowClk_d = intS;
         default: slowClk_d = 1'b0;
      endcase
      refSel_d = cfg_q[CFG_REF_SEL];
   end

   // Clock selection state.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         src_q <= SRC_OFF;
         intRun_q <= 1'b0;
         xtalEn_q <= 1'b0;
         slowClk_q <= 1'b0;
         refSel_q <= 1'b0;
      end else begin
         src_q <= src_d;
         intRun_q <= intRun_d;
         xtalEn_q <= xtalEn_d;
         slowClk_q <= slowClk_d;
         refSel_q <= refSel_d;
      end
   end

   assign slowClkSrc = src_q;
   assign intOscEnable = intRun_q;
   assign xtalOscEnable = xtalEn_q;
   assign slowClk = slowClk_q;
   assign refSelectSwitched = refSel_q;

   // ----------------------------------------------------------------
   // Pin power source.
   // ----------------------------------------------------------------
   logic genOut_q, genOut_d, genOe_q, genOe_d;
   logic ctrlOut_q, ctrlOut_d, ctrlOe_q, ctrlOe_d;

   // Battery powered pins always drive; rail powered ones float off.
   always_comb begin
      if (pwr_q[PWR_GEN_OUT]) begin
         genOut_d = batOut_q; // R9
         genOe_d = 1'b1;
      end else begin
         genOut_d = gpioGenOutLevel; // R8
         genOe_d = railS; // R8
      end
      if (pwr_q[PWR_CTRL_OUT]) begin
         ctrlOut_d = ctrlLogicLevel; // R10
         ctrlOe_d = 1'b1;
      end else begin
         ctrlOut_d = gpioCtrlOutLevel; // R8
         ctrlOe_d = railS; // R8
      end
   end

   // Pin output registers.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         genOut_q <= 1'b0;
         genOe_q <= 1'b0;
         ctrlOut_q <= 1'b0;
         ctrlOe_q <= 1'b0;
      end else begin
         genOut_q <= genOut_d;
         genOe_q <= genOe_d;
         ctrlOut_q <= ctrlOut_d;
         ctrlOe_q <= ctrlOe_d;
      end
   end

   assign genOutPin = genOut_q;
   assign genOutPinOe = genOe_q;
   assign ctrlOutPin = ctrlOut_q;
   assign ctrlOutPinOe = ctrlOe_q;
endmodule : scpp_top
`default_nettype wire

// ---- scpp_top_chk.sv ----
// Port checker for the slow clock and pin power block.
`timescale 1ns/1ps
`default_nettype none
module scpp_top_chk
   import scpp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mainRailGood,
   input wire scpp_pkg::scpp_src_t slowClkSrc,
   input wire logic intOscEnable,
   input wire logic genOutPinOe,
   input wire logic ctrlOutPinOe
);
   import scpp_pkg::*;
   // All checks run on the system clock and sleep during reset.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_b_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped before bready");
   chk_r_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before rready");
   chk_w_block: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_w_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   chk_r_answer: assert property (
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   chk_err_zero: assert property (
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   chk_oe_fall: assert property (
      $fell(genOutPinOe) || $fell(ctrlOutPinOe) |-> !$past(mainRailGood, 2)
      || !$past(mainRailGood, 3) || !$past(mainRailGood, 4))
      else $error("pin released while main rail on");
   chk_int_src: assert property (
      (slowClkSrc == SRC_INT) [*2] |-> intOscEnable || $past(intOscEnable))
      else $error("internal source selected with oscillator off");
endmodule : scpp_top_chk
`default_nettype wire

// ---- scpp_top_test.sv ----
// Self-checking bench for the slow clock and pin power block.
`timescale 1ns/1ps
`default_nettype none
module scpp_top_test;
   import scpp_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, extRun = 1'b1;
   logic mainRailGood = 1'b1, gpioGenOutLevel = 1'b0;
   logic gpioCtrlOutLevel = 1'b0, ctrlLogicLevel = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, slowClk, intOscEnable, xtalOscEnable;
   logic genOutPin, genOutPinOe, ctrlOutPin, ctrlOutPinOe, refSelectSwitched;
   logic xtalClkIn, extClkIn, intOscClkIn;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   scpp_src_t slowClkSrc;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;

   // ---------------------------------------------------------------
   // Clock, partner and device.
   // ---------------------------------------------------------------
   // The system clock toggles every half period of 2.5 ns.
   always #2.5 clk_sys = ~clk_sys;
   scpp_clk_model model (.extRun, .extClkIn, .xtalClkIn, .intOscClkIn);
   // Loss timeout shortened to 50 cycles; external period is 9 cycles.
   scpp_top #(.LOSS_CYC(16'h0032)) uut (.clk_sys, .rstn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xtalClkIn,
      .extClkIn, .intOscClkIn, .mainRailGood, .gpioGenOutLevel,
      .gpioCtrlOutLevel, .ctrlLogicLevel, .slowClk, .slowClkSrc,
      .intOscEnable, .xtalOscEnable, .refSelectSwitched, .genOutPin,
      .genOutPinOe, .ctrlOutPin, .ctrlOutPinOe);

   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic end_of_test();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic cmp(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt

   // Each channel drops its valid at the edge that takes it.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] st, input logic [1:0] rs);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      // The answer waits one cycle for bready, so its hold is exercised.
      s_axi_bready <= 1'b1;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
      cmp("bresp", 32'(rs), 32'(s_axi_bresp));
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] rs);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      // The read data waits one cycle for rready, so its hold is exercised.
      s_axi_rready <= 1'b1;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
      cmp("rdata", d, s_axi_rdata);
      cmp("rresp", 32'(rs), 32'(s_axi_rresp));
   endtask : axi_rd

   task automatic src_is(input scpp_src_t e, input int lim);
      int i = 0;
      while (slowClkSrc !== e && i < lim) begin
         @(posedge clk_sys);
         i++;
      end
      cmp("slowClkSrc", 32'(e), 32'(slowClkSrc));
   endtask : src_is

   // Counts level changes of the selected clock over 100 cycles.
   task automatic toggles(input logic run);
      int n = 0;
      logic last;
      last = slowClk;
      repeat (100) begin
         @(posedge clk_sys);
         if (slowClk !== last) n++;
         last = slowClk;
      end
      cmp("slowClk running", 32'(run), 32'(n > 4));
   endtask : toggles

   task automatic pins(input logic [3:0] e);
      cmp("pins", 32'(e), 32'({genOutPin, genOutPinOe, ctrlOutPin,
         ctrlOutPinOe}));
   endtask : pins

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   task automatic t_regs();
      axi_rd(ADDR_CLK_CFG, 32'h0, RESP_OKAY);
      axi_rd(ADDR_PIN_PWR, 32'h3, RESP_OKAY);
      axi_rd(ADDR_BAT_OUT, 32'h0, RESP_OKAY);
      axi_wr(ADDR_PIN_PWR, 32'hffff_fffe, 4'hf, RESP_OKAY);
      axi_rd(ADDR_PIN_PWR, 32'h2, RESP_OKAY);
      axi_wr(ADDR_PIN_PWR, 32'h1, 4'he, RESP_OKAY);
      axi_rd(ADDR_PIN_PWR, 32'h2, RESP_OKAY);
      axi_wr(8'h40, 32'h1, 4'hf, RESP_SLVERR);
      axi_rd(8'h40, 32'h0, RESP_SLVERR);
      axi_wr(ADDR_CLK_CFG, 32'h20, 4'h1, RESP_OKAY);
      axi_rd(ADDR_CLK_CFG, 32'h20, RESP_OKAY);
      cmp("refSelectSwitched", 32'h1, 32'(refSelectSwitched));
      axi_wr(ADDR_PIN_PWR, 32'h3, 4'hf, RESP_OKAY);
   endtask : t_regs

   // Non-switched modes; the last two run with the main rail off.
   task automatic t_modes();
      logic [5:0] cfg [9] = '{6'h00, 6'h02, 6'h06, 6'h03, 6'h17,
         CFG_BOOT_SAFE, 6'h0c, 6'h04, 6'h0c};
      scpp_src_t e [9] = '{SRC_OFF, SRC_XTAL, SRC_XTAL, SRC_EXT, SRC_EXT,
         SRC_INT, SRC_INT, SRC_INT, SRC_OFF};
      logic [8:0] on = 9'h07f;
      for (int i = 0; i < 9; i++) begin
         mainRailGood <= on[i];
         axi_wr(ADDR_CLK_CFG, 32'(cfg[i]), 4'h1, RESP_OKAY);
         src_is(e[i], 20);
         toggles(e[i] != SRC_OFF);
         cmp("xtalOscEnable", 32'(e[i] == SRC_XTAL),
            32'(xtalOscEnable));
         if (e[i] inside {SRC_INT, SRC_OFF}) begin
            cmp("intOscEnable", 32'(e[i] == SRC_INT), 32'(intOscEnable));
         end
      end
   endtask : t_modes

   task automatic t_switch();
      mainRailGood <= 1'b1;
      axi_wr(ADDR_CLK_CFG, 32'h07, 4'h1, RESP_OKAY);
      src_is(SRC_EXT, 100);
      extRun <= 1'b0;
      wt(30);
      cmp("slowClkSrc", 32'(SRC_EXT), 32'(slowClkSrc));
      src_is(SRC_INT, 60);
      extRun <= 1'b1;
      wt(15);
      cmp("slowClkSrc", 32'(SRC_INT), 32'(slowClkSrc));
      src_is(SRC_EXT, 100);
      mainRailGood <= 1'b0;
      src_is(SRC_INT, 20);
      toggles(1'b1);
      axi_wr(ADDR_CLK_CFG, 32'h0f, 4'h1, RESP_OKAY);
      src_is(SRC_OFF, 20);
      toggles(1'b0);
      mainRailGood <= 1'b1;
      src_is(SRC_EXT, 100);
      axi_rd(ADDR_STATUS, 32'h1e, RESP_OKAY);
   endtask : t_switch

   // GPIO levels oppose battery levels in the first and third checks so the chosen source shows.
   task automatic t_pins();
      ctrlLogicLevel <= 1'b1;
      mainRailGood <= 1'b0;
      axi_wr(ADDR_BAT_OUT, 32'h1, 4'h1, RESP_OKAY);
      wt(8);
      pins(4'hf);
      ctrlLogicLevel <= 1'b0;
      axi_wr(ADDR_BAT_OUT, 32'h0, 4'h1, RESP_OKAY);
      wt(8);
      pins(4'h5);
      gpioGenOutLevel <= 1'b1;
      gpioCtrlOutLevel <= 1'b1;
      mainRailGood <= 1'b1;
      axi_wr(ADDR_PIN_PWR, 32'h0, 4'h1, RESP_OKAY);
      wt(8);
      pins(4'hf);
      mainRailGood <= 1'b0;
      wt(8);
      cmp("pin enables", 32'h0, 32'({genOutPinOe, ctrlOutPinOe}));
   endtask : t_pins

   // Main sequence after three cycles of reset.
   initial begin
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_modes();
      t_switch();
      t_pins();
      end_of_test();
   end

   // A hang is cut short after 20000 cycles.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
endmodule : scpp_top_test

bind scpp_top scpp_top_chk chk (.clk_sys, .rstn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .mainRailGood, .slowClkSrc, .intOscEnable,
   .genOutPinOe, .ctrlOutPinOe);
`default_nettype wire
